// file: rtl/socket_pkg.sv
// Shared constants, types and address helpers for the accelerator socket.
package socket_pkg;

   // -----------------------------------------------------------------
   // Widths and counts
   // -----------------------------------------------------------------
   localparam int unsigned SOCKET_COUNT = 31;
   localparam int unsigned MAP_W        = 32;
   localparam int unsigned BUS_ADDR_W   = 16;
   localparam int unsigned WORD_W       = 32;
   localparam int unsigned LOCAL_ADDR_W = 9;
   localparam int unsigned EXT_ADDR_W   = 19;
   localparam int unsigned FIFO_DEPTH   = 8;
   localparam int unsigned REGION_WORDS = 512;

   // -----------------------------------------------------------------
   // Region bases of the four host address regions
   // -----------------------------------------------------------------
   localparam logic [15:0] REG_RD_BASE = 16'h0000;
   localparam logic [15:0] REG_WR_BASE = 16'h4000;
   localparam logic [15:0] RAM_RD_BASE = 16'h8000;
   localparam logic [15:0] RAM_WR_BASE = 16'hC000;

   // -----------------------------------------------------------------
   // Register indices in both register regions
   // -----------------------------------------------------------------
   localparam logic [8:0] RO_PRESENCE = 9'h000;
   localparam logic [8:0] RO_STATUS   = 9'h001;
   localparam logic [8:0] RO_PROGRESS = 9'h002;
   localparam logic [8:0] WO_CONTROL  = 9'h000;
   localparam logic [8:0] WO_EXT_ADDR = 9'h001;
   localparam logic [8:0] WO_COUNT    = 9'h002;

   // -----------------------------------------------------------------
   // Field positions and codes
   // -----------------------------------------------------------------
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_DIR_BIT   = 1;
   localparam int unsigned STAT_BUSY_BIT  = 0;
   localparam int unsigned STAT_DONE_BIT  = 1;
   localparam logic        JOB_DIR_READ   = 1'b1;
   localparam logic        JOB_DIR_WRITE  = 1'b0;

   typedef enum logic [1:0] {
      REGION_REG_RD = 2'b00,
      REGION_REG_WR = 2'b01,
      REGION_RAM_RD = 2'b10,
      REGION_RAM_WR = 2'b11
   } region_t;

   typedef enum logic [1:0] {
      JOB_IDLE  = 2'b00,
      JOB_ISSUE = 2'b01,
      JOB_MOVE  = 2'b10
   } job_state_t;

   // Region base for one socket.
   function automatic logic [15:0] socket_base(input region_t region, input logic [4:0] id);
      logic [15:0] base;
      case (region)
         REGION_REG_RD: base = REG_RD_BASE;
         REGION_REG_WR: base = REG_WR_BASE;
         REGION_RAM_RD: base = RAM_RD_BASE;
         default:       base = RAM_WR_BASE;
      endcase
      return base | (16'(id) << LOCAL_ADDR_W);
   endfunction

endpackage

// file: rtl/socket_region_decoder.sv
// Tells whether an access hits this socket's region.
`timescale 1ns/1ps
`default_nettype none
module socket_region_decoder #(
   parameter logic [4:0] SOCKET_ID = 5'h01
) (
   input  wire logic [15:0]              addr,
   input  wire socket_pkg::region_t      region,
   output logic                          hit,
   output logic [8:0]                    offset
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Upper bits match this socket's region; nine low bits pick the location.
   always_comb begin
      logic [15:0] base;
      base   = socket_pkg::socket_base(region, SOCKET_ID);
      hit    = (addr[15:socket_pkg::LOCAL_ADDR_W] == base[15:socket_pkg::LOCAL_ADDR_W]);
      offset = addr[socket_pkg::LOCAL_ADDR_W-1:0];
   end

endmodule
`default_nettype wire

// file: rtl/socket_word_fifo.sv
// Flip-flop FIFO, valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module socket_word_fifo #(
   parameter int unsigned WIDTH = 43,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);

   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
   } fifo_state_t;

   fifo_state_t st_reg;
   fifo_state_t st_next;

   // Wrap a pointer at the last slot.
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready  = (st_reg.count != CW'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rd_ptr];
   assign level     = st_reg.count;

   // Push and pop; both may happen in one cycle.
   always_comb begin
      logic push;
      logic pop;
      push    = in_valid & in_ready;
      pop     = out_valid & out_ready;
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr             = bump(st_reg.wr_ptr);
      end
      if (pop) begin
         st_next.rd_ptr = bump(st_reg.rd_ptr);
      end
      st_next.count = st_reg.count + CW'(push) - CW'(pop);
   end

   // State register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule
`default_nettype wire

// file: rtl/accel_socket.sv
// One accelerator socket with host ports, buffer and external job port.
`timescale 1ns/1ps
`default_nettype none
module accel_socket #(
   parameter logic [4:0]  SOCKET_ID      = 5'h01,
   parameter logic        ACCEL_FITTED   = 1'b1,
   parameter int unsigned RAM_WORDS      = socket_pkg::REGION_WORDS,
   parameter int unsigned FIFO_DEPTH     = socket_pkg::FIFO_DEPTH
) (
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          strobe_reg_read,
   input  wire logic          strobe_reg_write,
   input  wire logic          strobe_ram_read,
   input  wire logic          strobe_ram_write,
   input  wire logic [15:0]   write_addr,
   input  wire logic [31:0]   data_in,
   input  wire logic          write_valid,
   output logic               write_rdy,
   input  wire logic [15:0]   read_addr,
   output logic [31:0]        data_out,
   output logic               strobe_out,
   input  wire logic          ext_rfifo_empty,
   input  wire logic          ext_wfifo_full,
   input  wire logic          ext_job_accepted,
   input  wire logic          ext_wfifo_granted,
   input  wire logic          ext_rfifo_granted,
   input  wire logic [31:0]   ext_rd_word,
   output logic               ext_job_request,
   output logic               ext_job_dir,
   output logic               ext_rfifo_take,
   output logic               ext_wfifo_put,
   output logic [18:0]        ext_mem_location,
   output logic [31:0]        ext_wr_word
);

   // ----------------------------------------------------------------
   // Local sizes
   // ----------------------------------------------------------------
   localparam int unsigned AW = socket_pkg::LOCAL_ADDR_W;
   localparam int unsigned CW = AW + 1;
   localparam int unsigned LW = $clog2(FIFO_DEPTH+1);
   localparam int unsigned FW = 2 + AW + socket_pkg::WORD_W;

   typedef struct packed {
      socket_pkg::job_state_t                     state;
      logic                                       dir;
      logic [socket_pkg::EXT_ADDR_W-1:0]          ext_loc;
      logic [CW-1:0]                              count;
      logic [CW-1:0]                              idx;
      logic                                       done;
      logic                                       job_req;
      logic                                       take;
      logic                                       put;
      logic [socket_pkg::WORD_W-1:0]              wr_word;
      logic [socket_pkg::WORD_W-1:0]              rd_out;
      logic                                       rd_strobe;
      logic                                       wr_rdy;
      logic [RAM_WORDS-1:0][socket_pkg::WORD_W-1:0] in_ram;
      logic [RAM_WORDS-1:0][socket_pkg::WORD_W-1:0] out_ram;
   } socket_state_t;

   socket_state_t st_reg;
   socket_state_t st_next;

   // ----------------------------------------------------------------
   // Presence map
   // ----------------------------------------------------------------
   // Only a fitted socket 1 to 31 shows its bit.
   function automatic logic [socket_pkg::MAP_W-1:0] presence_map();
      logic [socket_pkg::MAP_W-1:0] map;
      map = '0;
      if (ACCEL_FITTED && (SOCKET_ID != 5'h00) && (32'(SOCKET_ID) <= socket_pkg::SOCKET_COUNT)) begin
         map[SOCKET_ID] = 1'b1;
      end
      return map;
   endfunction

   // ----------------------------------------------------------------
   // Address decode of both host ports
   // ----------------------------------------------------------------
   logic                wr_hit;
   logic [AW-1:0]       wr_off;
   logic                rd_hit;
   logic [AW-1:0]       rd_off;
   socket_pkg::region_t wr_region;
   socket_pkg::region_t rd_region;

   // The RAM strobe picks the RAM region; otherwise the register region is meant.
   assign wr_region = strobe_ram_write ? socket_pkg::REGION_RAM_WR : socket_pkg::REGION_REG_WR;
   assign rd_region = strobe_ram_read ? socket_pkg::REGION_RAM_RD : socket_pkg::REGION_REG_RD;

   socket_region_decoder #(
      .SOCKET_ID (SOCKET_ID)
   ) u_wr_dec (
      .addr   (write_addr),
      .region (wr_region),
      .hit    (wr_hit),
      .offset (wr_off)
   );

   socket_region_decoder #(
      .SOCKET_ID (SOCKET_ID)
   ) u_rd_dec (
      .addr   (read_addr),
      .region (rd_region),
      .hit    (rd_hit),
      .offset (rd_off)
   );

   // ----------------------------------------------------------------
   // Inbound word buffer
   // ----------------------------------------------------------------
   logic               wr_strobe;
   logic               fifo_push;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   logic               fifo_out_ready;
   logic [FW-1:0]      fifo_in_data;
   logic [FW-1:0]      fifo_out_data;
   logic [LW-1:0]      fifo_level;

   // Take a word under a strobe with qualifier and ready high.
   assign wr_strobe    = strobe_reg_write | strobe_ram_write;
   assign fifo_push    = wr_strobe & write_valid & st_reg.wr_rdy & fifo_in_ready;
   assign fifo_in_data = {wr_hit, strobe_ram_write, wr_off, data_in};

   // Hold the buffer through a write job so the input RAM is not overwritten.
   assign fifo_out_ready = !((st_reg.state != socket_pkg::JOB_IDLE) && (st_reg.dir == socket_pkg::JOB_DIR_WRITE));

   socket_word_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   // ----------------------------------------------------------------
   // Read lookup
   // ----------------------------------------------------------------
   // Read-only registers and RAM as seen by the host.
   function automatic logic [socket_pkg::WORD_W-1:0] read_word(input socket_state_t s,
                                                               input logic is_ram,
                                                               input logic [AW-1:0] off);
      logic [socket_pkg::WORD_W-1:0] w;
      w = '0;
      if (is_ram) begin
         if (32'(off) < RAM_WORDS) begin
            w = s.out_ram[off];
         end
      end else begin
         case (off)
            socket_pkg::RO_PRESENCE: w = presence_map();
            socket_pkg::RO_STATUS: begin
               w[socket_pkg::STAT_BUSY_BIT] = (s.state != socket_pkg::JOB_IDLE);
               w[socket_pkg::STAT_DONE_BIT] = s.done;
            end
            socket_pkg::RO_PROGRESS: w[CW-1:0] = s.idx;
            default: w = '0;
         endcase
      end
      return w;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Host reads, buffered writes and the external job.
   always_comb begin
      logic                 is_ram;
      logic                 hit;
      logic [AW-1:0]        off;
      logic [31:0]          word;
      logic                 start;
      logic                 drain;
      logic [LW:0]          fill;
      is_ram  = fifo_out_data[FW-2];
      hit     = fifo_out_data[FW-1];
      off     = fifo_out_data[socket_pkg::WORD_W +: AW];
      word    = fifo_out_data[socket_pkg::WORD_W-1:0];
      drain   = fifo_out_valid & fifo_out_ready;
      start   = 1'b0;
      st_next = st_reg;

      // Answer any read strobe a cycle later; misses read zero.
      st_next.rd_strobe = strobe_reg_read | strobe_ram_read;
      st_next.rd_out    = rd_hit ? read_word(st_reg, strobe_ram_read, rd_off) : '0;

      // Ready only while room remains after this cycle's word.
      fill           = (LW+1)'(fifo_level) + (LW+1)'(fifo_push);
      st_next.wr_rdy = (fill < (LW+1)'(FIFO_DEPTH));

      // Each buffered word that hits lands at its own location; direction, address and count load only while idle.
      if (drain && hit) begin
         if (is_ram) begin
            if (32'(off) < RAM_WORDS) begin
               st_next.in_ram[off] = word;
            end
         end else begin
            case (off)
               socket_pkg::WO_CONTROL: begin
                  start       = word[socket_pkg::CTRL_START_BIT];
                  if (st_reg.state == socket_pkg::JOB_IDLE) begin
                     st_next.dir = word[socket_pkg::CTRL_DIR_BIT];
                  end
               end
               socket_pkg::WO_EXT_ADDR: begin
                  if (st_reg.state == socket_pkg::JOB_IDLE) begin
                     st_next.ext_loc = word[socket_pkg::EXT_ADDR_W-1:0];
                  end
               end
               socket_pkg::WO_COUNT: begin
                  if (st_reg.state == socket_pkg::JOB_IDLE) begin
                     st_next.count = word[CW-1:0];
                  end
               end
               default: ;
            endcase
         end
      end

      // External memory job sequence.
      st_next.job_req = 1'b0;
      st_next.put     = 1'b0;
      st_next.take    = 1'b0;
      case (st_reg.state)
         socket_pkg::JOB_IDLE: begin
            if (start) begin
               st_next.done    = 1'b0;
               st_next.idx     = '0;
               st_next.job_req = 1'b1;
               st_next.state   = socket_pkg::JOB_ISSUE;
            end
         end
         socket_pkg::JOB_ISSUE: begin
            if (ext_job_accepted) begin
               st_next.state = socket_pkg::JOB_MOVE;
            end
         end
         socket_pkg::JOB_MOVE: begin
            if (st_reg.dir == socket_pkg::JOB_DIR_READ) begin
               // Store at the edge where take is high.
               if (st_reg.take) begin
                  if (32'(st_reg.idx) < RAM_WORDS) begin
                     st_next.out_ram[st_reg.idx[AW-1:0]] = ext_rd_word;
                  end
                  st_next.idx = st_reg.idx + 1'b1;
               end else if (st_reg.idx == st_reg.count) begin
                  st_next.done  = 1'b1;
                  st_next.state = socket_pkg::JOB_IDLE;
               end else if (ext_rfifo_granted && !ext_rfifo_empty) begin
                  st_next.take = 1'b1;
               end
            end else begin
               // Words leave the input RAM in order, at most one put every other cycle.
               if (st_reg.put) begin
                  st_next.idx = st_reg.idx + 1'b1;
               end else if (st_reg.idx == st_reg.count) begin
                  st_next.done  = 1'b1;
                  st_next.state = socket_pkg::JOB_IDLE;
               end else if (ext_wfifo_granted && !ext_wfifo_full) begin
                  st_next.put     = 1'b1;
                  st_next.wr_word = (32'(st_reg.idx) < RAM_WORDS) ? st_reg.in_ram[st_reg.idx[AW-1:0]] : '0;
               end
            end
         end
         default: begin
            st_next.state = socket_pkg::JOB_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Rising-edge state, cleared by a high reset.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg       <= '0;
         st_reg.state <= socket_pkg::JOB_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Outputs straight from the state register.
   assign write_rdy        = st_reg.wr_rdy;
   assign data_out         = st_reg.rd_out;
   assign strobe_out       = st_reg.rd_strobe;
   assign ext_job_request  = st_reg.job_req;
   assign ext_job_dir      = st_reg.dir;
   assign ext_mem_location = st_reg.ext_loc;
   assign ext_rfifo_take   = st_reg.take;
   assign ext_wfifo_put    = st_reg.put;
   assign ext_wr_word      = st_reg.wr_word;

endmodule
`default_nettype wire

// file: verification/accel_socket_asserts.sv
// Port assertions for the accelerator socket.
`timescale 1ns/1ps
`default_nettype none
module accel_socket_asserts #(
   parameter logic [4:0] SOCKET_ID    = 5'h01,
   parameter logic       ACCEL_FITTED = 1'b1
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        strobe_reg_read,
   input wire logic        strobe_ram_read,
   input wire logic [15:0] read_addr,
   input wire logic [31:0] data_out,
   input wire logic        strobe_out,
   input wire logic        ext_rfifo_empty,
   input wire logic        ext_wfifo_full,
   input wire logic        ext_wfifo_granted,
   input wire logic        ext_rfifo_granted,
   input wire logic        ext_job_request,
   input wire logic        ext_rfifo_take,
   input wire logic        ext_wfifo_put
);
   // Expected map and region hit.
   localparam logic [31:0] MAP = ACCEL_FITTED ? (32'h1 << SOCKET_ID) : 32'h0;
   logic hit;
   assign hit = read_addr[15:9] == {strobe_ram_read, 1'b0, SOCKET_ID};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence rd_req;
      strobe_reg_read || strobe_ram_read;
   endsequence
   rd_answer_a: assert property (rd_req |=> strobe_out)
      else $error("read not answered");
   rd_only_a: assert property (strobe_out |-> $past(strobe_reg_read || strobe_ram_read))
      else $error("answer without read");
   presence_map_a: assert property (strobe_reg_read && read_addr == {2'b00, SOCKET_ID, 9'h000} |=> data_out == MAP)
      else $error("presence map wrong");
   stray_read_a: assert property ((strobe_reg_read || strobe_ram_read) && !hit |=> data_out == 32'h0)
      else $error("foreign read not zero");
   put_ok_a: assert property (ext_wfifo_put |-> $past(ext_wfifo_granted && !ext_wfifo_full))
      else $error("put without grant");
   take_ok_a: assert property (ext_rfifo_take |-> $past(ext_rfifo_granted && !ext_rfifo_empty))
      else $error("take without grant");
   put_gap_a: assert property (ext_wfifo_put |=> !ext_wfifo_put)
      else $error("puts too close");
   take_gap_a: assert property (ext_rfifo_take |=> !ext_rfifo_take)
      else $error("takes too close");
   job_pulse_a: assert property (ext_job_request |=> !ext_job_request [*2])
      else $error("job request not a pulse");
endmodule
bind accel_socket accel_socket_asserts #(.SOCKET_ID(SOCKET_ID), .ACCEL_FITTED(ACCEL_FITTED)) chk (.*);
`default_nettype wire

// file: verification/ext_mem_model.sv
// External memory manager model.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        stall,
   input  wire logic        ext_job_request,
   input  wire logic        ext_job_dir,
   input  wire logic        ext_rfifo_take,
   input  wire logic        ext_wfifo_put,
   input  wire logic [18:0] ext_mem_location,
   input  wire logic [31:0] ext_wr_word,
   output logic             ext_rfifo_empty,
   output logic             ext_wfifo_full,
   output logic             ext_job_accepted,
   output logic             ext_wfifo_granted,
   output logic             ext_rfifo_granted,
   output logic [31:0]      ext_rd_word
);
   logic [1:0]  ph_reg;
   logic        pend_reg, rd_on_reg, dir_reg;
   logic [7:0]  rd_n_reg, wr_n_reg;
   logic [18:0] loc_reg;
   logic [31:0] log_reg [16];
   // Grants follow a phase; a stall holds grants and jobs back.
   assign ext_wfifo_granted = !stall && ph_reg[0];
   assign ext_rfifo_granted = !stall && ph_reg[1];
   assign ext_wfifo_full    = ph_reg == 2'h3;
   assign ext_job_accepted  = pend_reg && !stall;
   // Numbered words after a read job, inverted before.
   assign ext_rfifo_empty   = !rd_on_reg;
   assign ext_rd_word = rd_on_reg ? 32'hA5A50000 + 32'(rd_n_reg) : ~(32'hA5A50000 + 32'(rd_n_reg));
   // Logs jobs and put words; counts takes.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_reg    <= 2'h0;
         pend_reg  <= 1'b0;
         rd_on_reg <= 1'b0;
         rd_n_reg  <= 8'h0;
         wr_n_reg  <= 8'h0;
      end else begin
         ph_reg   <= ph_reg + 2'h1;
         pend_reg <= ext_job_request || (pend_reg && stall);
         if (ext_job_request) begin
            dir_reg   <= ext_job_dir;
            loc_reg   <= ext_mem_location;
            rd_on_reg <= rd_on_reg || ext_job_dir;
         end
         if (ext_rfifo_take) rd_n_reg <= rd_n_reg + 8'h1;
         if (ext_wfifo_put) begin
            log_reg[wr_n_reg[3:0]] <= ext_wr_word;
            wr_n_reg <= wr_n_reg + 8'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the accelerator socket.
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic ram; logic [15:0] a; logic [31:0] q;} row_t;
   logic        sys_clk, sys_rst, stall, write_valid, write_rdy, strobe_out, ext_job_dir;
   logic        strobe_reg_read, strobe_reg_write, strobe_ram_read, strobe_ram_write;
   logic        ext_rfifo_empty, ext_wfifo_full, ext_job_accepted, ext_wfifo_granted, ext_rfifo_granted;
   logic        ext_job_request, ext_rfifo_take, ext_wfifo_put;
   logic [15:0] write_addr, read_addr;
   logic [18:0] ext_mem_location;
   logic [31:0] data_in, data_out, ext_rd_word, ext_wr_word, q;
   int          failures = 0, check_count = 0, acc;
   row_t        rows [5] = '{'{0, 16'h0200, 32'h2}, '{0, 16'h0400, 32'h0}, '{0, 16'h0201, 32'h0},
                             '{0, 16'h4200, 32'h0}, '{1, 16'h8400, 32'h0}};
   accel_socket #(.SOCKET_ID(5'h01), .ACCEL_FITTED(1'b1), .RAM_WORDS(16)) uut (
      .sys_clk, .sys_rst, .strobe_reg_read, .strobe_reg_write, .strobe_ram_read, .strobe_ram_write,
      .write_addr, .data_in, .write_valid, .write_rdy, .read_addr, .data_out, .strobe_out,
      .ext_rfifo_empty, .ext_wfifo_full, .ext_job_accepted, .ext_wfifo_granted, .ext_rfifo_granted,
      .ext_rd_word, .ext_job_request, .ext_job_dir, .ext_rfifo_take, .ext_wfifo_put,
      .ext_mem_location, .ext_wr_word);
   ext_mem_model mem (.sys_clk, .sys_rst, .stall, .ext_job_request, .ext_job_dir, .ext_rfifo_take,
      .ext_wfifo_put, .ext_mem_location, .ext_wr_word, .ext_rfifo_empty, .ext_wfifo_full,
      .ext_job_accepted, .ext_wfifo_granted, .ext_rfifo_granted, .ext_rd_word);
   // Free-running 200 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Counts and reports a comparison.
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (!ok) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One read strobe; answer one cycle later.
   task automatic rd(input logic ram, input logic [15:0] a);
      @(negedge sys_clk);
      strobe_reg_read <= !ram;
      strobe_ram_read <= ram;
      read_addr <= a;
      @(negedge sys_clk);
      chk(strobe_out === 1'b1, "no read answer");
      q = data_out;
      strobe_reg_read <= 1'b0;
      strobe_ram_read <= 1'b0;
   endtask
   // One write word, held until taken; without valid, offered once.
   task automatic wr(input logic ram, input logic [15:0] a, input logic [31:0] d, input logic v);
      int n;
      @(negedge sys_clk);
      strobe_reg_write <= !ram;
      strobe_ram_write <= ram;
      write_addr <= a;
      data_in <= d;
      write_valid <= v;
      for (n = 0; v && write_rdy !== 1'b1 && n < 50; n++) @(negedge sys_clk);
      if (n == 50) begin
         failures++;
         tally_and_finish();
      end
      @(negedge sys_clk);
      strobe_reg_write <= 1'b0;
      strobe_ram_write <= 1'b0;
      write_valid <= 1'b0;
   endtask
   // Polls status for busy, or for a seen job's end.
   task automatic wait_job(input logic busy_only);
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < 100; n++) begin
         rd(1'b0, 16'h0201);
         seen = seen | q[0];
         if (busy_only ? q[0] === 1'b1 : (seen && q[1:0] === 2'h2)) break;
      end
      if (n == 100) begin
         failures++;
         tally_and_finish();
      end
   endtask
   // Reset, read table, jobs, buffer fill, second reset.
   initial begin
      {strobe_reg_read, strobe_reg_write, strobe_ram_read, strobe_ram_write, write_valid, stall} = 6'h0;
      {write_addr, read_addr, data_in} = '0;
      sys_rst = 1'b1;
      repeat (16) @(negedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i <= 5; i++) begin
         @(negedge sys_clk);
         if (i > 0) chk(strobe_out === 1'b1 && data_out === rows[i-1].q, "read row");
         strobe_reg_read <= i < 5 && !rows[i % 5].ram;
         strobe_ram_read <= i < 5 && rows[i % 5].ram;
         read_addr <= rows[i % 5].a;
      end
      $display("test reads done");
      wr(1'b1, 16'hC200, 32'h1111AAAA, 1'b1);
      wr(1'b1, 16'hC201, 32'h2222BBBB, 1'b1);
      wr(1'b1, 16'hC202, 32'h3333CCCC, 1'b1);
      wr(1'b1, 16'hC200, 32'hDEADDEAD, 1'b0);
      wr(1'b0, 16'h4201, 32'h00012345, 1'b1);
      wr(1'b0, 16'h4202, 32'h00000003, 1'b1);
      wr(1'b0, 16'h4200, 32'h00000001, 1'b1);
      wait_job(1'b0);
      chk(mem.wr_n_reg === 8'h03 && mem.dir_reg === 1'b0 && mem.loc_reg === 19'h12345, "write job");
      chk(mem.log_reg[0] === 32'h1111AAAA && mem.log_reg[2] === 32'h3333CCCC, "written words");
      wr(1'b0, 16'h4202, 32'h00000002, 1'b1);
      wr(1'b0, 16'h4200, 32'h00000003, 1'b1);
      wait_job(1'b0);
      rd(1'b1, 16'h8200);
      chk(q === 32'hA5A50000 && mem.dir_reg === 1'b1, "read word 0");
      rd(1'b1, 16'h8201);
      chk(q === 32'hA5A50001, "read word 1");
      $display("test jobs done");
      stall <= 1'b1;
      wr(1'b0, 16'h4202, 32'h00000001, 1'b1);
      wr(1'b0, 16'h4200, 32'h00000001, 1'b1);
      wait_job(1'b1);
      strobe_ram_write <= 1'b1;
      write_valid <= 1'b1;
      acc = 0;
      for (int i = 0; i < 12; i++) begin
         write_addr <= 16'hC200 + 16'(i);
         data_in <= 32'(i);
         acc += int'(write_rdy === 1'b1);
         @(negedge sys_clk);
      end
      strobe_ram_write <= 1'b0;
      write_valid <= 1'b0;
      stall <= 1'b0;
      chk(acc == 8, "buffer fill");
      wait_job(1'b0);
      $display("test fill done");
      sys_rst <= 1'b1;
      @(negedge sys_clk);
      chk(write_rdy === 1'b0 && ext_job_request === 1'b0 && strobe_out === 1'b0, "reset outputs");
      sys_rst <= 1'b0;
      rd(1'b0, 16'h0201);
      chk(q === 32'h0, "status after reset");
      $display("test reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
